/* File: hdl/iomd_pkg.sv */
// Package for the I/O and memory address decoder: register map, targets
// and the fixed I/O map. Assumes a single 10 MHz clock and APB access.
package iomd_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FWH_EN = 8'h04;
  localparam logic [7:0] OFS_PM_BASE = 8'h08;
  localparam logic [7:0] OFS_GPIO_BASE = 8'h0c;
  localparam logic [7:0] OFS_LPC_GEN = 8'h10;
  localparam logic [7:0] OFS_P2P = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int CTRL_F0EN = 0;
  localparam int CTRL_PRI = 1;
  localparam int CTRL_SEC = 2;
  localparam int CTRL_SUBTR = 3;
  localparam int CTRL_SWAP = 4;
  localparam int FWH_LEGACY_BIT = 7;

  // ----------------------------------------------------------------------
  // Memory windows
  // ----------------------------------------------------------------------
  localparam logic [31:0] IOAPIC_LO = 32'hfec0_0000;
  localparam logic [31:0] IOAPIC_HI = 32'hfec0_0100;
  localparam logic [9:0] FWH_TOP4M = 10'h3ff;
  localparam logic [9:0] FWH_ALIAS4M = 10'h3fe;
  localparam logic [9:0] FWH2_TOP = 10'h3fd;
  localparam logic [9:0] FWH2_ALIAS = 10'h3fc;
  localparam logic [14:0] FWH_LEGACY = 15'h0007;
  localparam logic [14:0] BIOS_SWAP_BLK = 15'h7fff;
  localparam int SWAP_BIT = 16;
  localparam logic [10:0] HEALTH_OFS = 11'h003;

  typedef enum logic [3:0] {
    TGT_PASS = 4'h0, TGT_DMA = 4'h1, TGT_PIC = 4'h2, TGT_PIT = 4'h3,
    TGT_LPC = 4'h4, TGT_NMI = 4'h5, TGT_RTC = 4'h6, TGT_RSTGEN = 4'h7,
    TGT_PM = 4'h8, TGT_FERR = 4'h9, TGT_DISK = 4'ha, TGT_HEALTH = 4'hb,
    TGT_GPIO = 4'hc, TGT_IOAPIC = 4'hd, TGT_FWH = 4'he, TGT_HUB = 4'hf
  } iomd_tgt_e;

  // ----------------------------------------------------------------------
  // Fixed I/O map; write-only ports fall to PASS on reads.
  // ----------------------------------------------------------------------
  function automatic iomd_tgt_e iomd_fixed_io(input logic [15:0] a, input logic wr,
                                              input logic f0en, input logic pri,
                                              input logic sec);
    iomd_tgt_e t;
    t = TGT_PASS;
    if (a inside {[16'h000:16'h008], 16'h00f, [16'h010:16'h018], 16'h01f,
                  [16'h080:16'h091], [16'h093:16'h09f], [16'hc0:16'hd1], [16'hde:16'hdf]})
      t = TGT_DMA;
    else if (wr && a inside {[16'h009:16'h00e], [16'h019:16'h01e], [16'hd2:16'hdd]})
      t = TGT_DMA;
    else if (a[15:8] == 8'h00 && !a[1] && (a[7:5] == 3'h1 || a[7:5] == 3'h5))
      t = TGT_PIC;
    else if (a inside {16'h4d0, 16'h4d1})
      t = TGT_PIC;
    else if (a inside {[16'h040:16'h042], [16'h050:16'h052]} || (wr && a inside {16'h43, 16'h53}))
      t = TGT_PIT;
    else if (a inside {16'h2e, 16'h2f, 16'h4e, 16'h4f, 16'h60, 16'h62, 16'h64, 16'h66})
      t = TGT_LPC;
    else if (a inside {16'h61, 16'h63, 16'h65, 16'h67})
      t = TGT_NMI;
    else if (a inside {[16'h071:16'h077]} || (wr && a == 16'h070))
      t = TGT_RTC;
    else if (a inside {16'h092, 16'hcf9})
      t = TGT_RSTGEN;
    else if (a inside {16'h0b2, 16'h0b3})
      t = TGT_PM;
    else if (a == 16'h0f0)
      t = wr ? TGT_FERR : (f0en ? TGT_PASS : TGT_LPC);
    else if (pri && a inside {[16'h1f0:16'h1f7], 16'h3f6})
      t = TGT_DISK;
    else if (sec && a inside {[16'h170:16'h177], 16'h376})
      t = TGT_DISK;
    return t;
  endfunction

  function automatic logic iomd_page_fwd(input logic [15:0] a);
    return a inside {16'h080, [16'h084:16'h086], 16'h088, [16'h08c:16'h08e]};
  endfunction

  function automatic logic iomd_nmi_upd(input logic [15:0] a);
    return a inside {16'h070, 16'h072, 16'h074, 16'h076};
  endfunction

endpackage

/* File: hdl/iomd_decoder.sv */
// Address decoder that classifies each I/O or memory cycle and routes it.
// Assumes cycles are presented one clock wide and synchronous to clock_in;
// rst_b_in is the battery-well reset, host_bus_reset_n_in the bus reset.
`timescale 1ns/1ps

// What this block does
// - Unclaimed host I/O cycles pass to PCI
// - PCI master fixed I/O claimed, medium timing
// - DMA ranges, some write-only
// - Interrupt controller ports and their aliases
// - Timer ports, control ports write-only
// - Super-I/O and keyboard ports go to LPC
// - Port 61h and aliases go to NMI logic
// - Clock unit ports, some writes update NMI
// - Page register writes also forwarded outward
// - Reset generator and power-management ports claimed
// - F0h write to error logic, read gated
// - Disk ranges only when channel enabled
// - Variable ranges decoded, LPC ones forwarded
// - Health range sits 96 above PM base
// - Host memory cycles go to PCI first
// - PCI master memory sent up unless peer
// - Firmware window enable bits gate decode
// - Top firmware window always decoded
// - I/O APIC memory window claimed
// - Swap bit inverts A16 in BIOS space
// - Swap bit survives bus reset only
// - Swap leaves feature space untouched
// - Strap-forced swap cannot be cleared
module iomd_decoder
  import iomd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic host_bus_reset_n_in,
  input wire logic swap_strap_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cyc_valid_in,
  input wire logic cyc_mem_in,
  input wire logic cyc_write_in,
  input wire logic cyc_from_pci_in,
  input wire logic [31:0] cyc_addr_in,
  output logic dec_valid_out,
  output logic [3:0] dec_target_out,
  output logic dec_claim_out,
  output logic dec_to_pci_out,
  output logic dec_also_fwd_out,
  output logic dec_nmi_upd_out,
  output logic [31:0] dec_addr_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ctrl;
    logic swap_sw;
    logic strap;
    logic strap_done;
    logic [11:0] fwh_en;
    logic [9:0] pm_base;
    logic [9:0] gpio_base;
    logic [8:0] gen_base;
    logic gen_en;
    logic [11:0] p2p_base;
    logic [11:0] p2p_lim;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dvalid;
    iomd_tgt_e dtgt;
    logic dclaim;
    logic dpci;
    logic dfwd;
    logic dnmi;
    logic [31:0] daddr;
  } iomd_st_s;

  iomd_st_s st_ff;
  iomd_st_s nxt_st;

  // Decoding of the APB offset, used by both read and write paths.
  function automatic logic mapped(input logic [7:0] a);
    return a inside {OFS_CTRL, OFS_FWH_EN, OFS_PM_BASE, OFS_GPIO_BASE,
                     OFS_LPC_GEN, OFS_P2P, OFS_STATUS};
  endfunction

  logic swap_eff;
  logic [15:0] io_a;
  logic apb_wr;
  logic fwh_hit;
  logic apic_hit;
  logic p2p_hit;
  logic bios_top;
  iomd_tgt_e io_tgt;
  iomd_tgt_e var_tgt;

  // ----------------------------------------------------------------------
  // Memory window decode
  // ----------------------------------------------------------------------
  // The strap forces the swap; software can only add to it, never clear it.
  assign swap_eff = st_ff.swap_sw | st_ff.strap;
  assign io_a = cyc_addr_in[15:0];
  assign apb_wr = psel && penable && st_ff.pready && pwrite && mapped(paddr);
  assign apic_hit = cyc_addr_in >= IOAPIC_LO && cyc_addr_in <= IOAPIC_HI;
  assign bios_top = cyc_addr_in[31:17] == BIOS_SWAP_BLK;
  assign p2p_hit = cyc_addr_in[31:20] >= st_ff.p2p_base && cyc_addr_in[31:20] <= st_ff.p2p_lim;

  // Top-region windows of 512 KB, second-region windows of 1 MB: index seven is the always-on top window.
  always_comb begin
    fwh_hit = 1'b0;
    if (cyc_addr_in[31:22] == FWH_TOP4M || cyc_addr_in[31:22] == FWH_ALIAS4M) begin
      fwh_hit = (cyc_addr_in[21:19] == 3'h7) || st_ff.fwh_en[cyc_addr_in[21:19]];
    end else if (cyc_addr_in[31:22] == FWH2_TOP || cyc_addr_in[31:22] == FWH2_ALIAS) begin
      fwh_hit = st_ff.fwh_en[{2'h2, cyc_addr_in[21:20]}];
    end else if (cyc_addr_in[31:17] == FWH_LEGACY) begin
      fwh_hit = st_ff.fwh_en[FWH_LEGACY_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // I/O decode: fixed map first, then the movable ranges
  // ----------------------------------------------------------------------
  // Overlaps between fixed and variable ranges are not checked; fixed wins.
  always_comb begin
    io_tgt = iomd_fixed_io(io_a, cyc_write_in, st_ff.ctrl[CTRL_F0EN],
                           st_ff.ctrl[CTRL_PRI], st_ff.ctrl[CTRL_SEC]);
    var_tgt = TGT_PASS;
    if (io_a[15:6] == st_ff.pm_base) begin
      var_tgt = TGT_PM;
    end else if (io_a[15:5] == {st_ff.pm_base, 1'b0} + HEALTH_OFS) begin
      var_tgt = TGT_HEALTH;
    end else if (io_a[15:6] == st_ff.gpio_base) begin
      var_tgt = TGT_GPIO;
    end else if (st_ff.gen_en && io_a[15:7] == st_ff.gen_base) begin
      var_tgt = TGT_LPC;
    end
  end

  // ----------------------------------------------------------------------
  // Next state: APB slave, configuration and cycle routing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // One wait state: pready rises in the second access cycle.
    nxt_st.pready = psel && penable && !st_ff.pready;
    nxt_st.pslverr = nxt_st.pready && !mapped(paddr);
    nxt_st.prdata = '0;
    if (nxt_st.pready && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: nxt_st.prdata = 32'({swap_eff, st_ff.ctrl});
        OFS_FWH_EN: nxt_st.prdata = 32'(st_ff.fwh_en);
        OFS_PM_BASE: nxt_st.prdata = 32'({st_ff.pm_base, 6'h00});
        OFS_GPIO_BASE: nxt_st.prdata = 32'({st_ff.gpio_base, 6'h00});
        OFS_LPC_GEN: nxt_st.prdata = 32'({st_ff.gen_base, 6'h00, st_ff.gen_en});
        OFS_P2P: nxt_st.prdata = {4'h0, st_ff.p2p_lim, 4'h0, st_ff.p2p_base};
        OFS_STATUS: nxt_st.prdata = 32'({st_ff.strap, st_ff.dtgt});
        default: nxt_st.prdata = '0;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          nxt_st.ctrl = pwdata[3:0];
          nxt_st.swap_sw = pwdata[CTRL_SWAP];
        end
        OFS_FWH_EN: nxt_st.fwh_en = pwdata[11:0];
        OFS_PM_BASE: nxt_st.pm_base = pwdata[15:6];
        OFS_GPIO_BASE: nxt_st.gpio_base = pwdata[15:6];
        OFS_LPC_GEN: begin
          nxt_st.gen_base = pwdata[15:7];
          nxt_st.gen_en = pwdata[0];
        end
        OFS_P2P: begin
          nxt_st.p2p_base = pwdata[11:0];
          nxt_st.p2p_lim = pwdata[27:16];
        end
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    // Bus reset clears configuration but spares the swap bit and strap.
    if (!host_bus_reset_n_in) begin
      nxt_st.ctrl = '0;
      nxt_st.fwh_en = '0;
      nxt_st.pm_base = '0;
      nxt_st.gpio_base = '0;
      nxt_st.gen_base = '0;
      nxt_st.gen_en = 1'b0;
      nxt_st.p2p_base = '0;
      nxt_st.p2p_lim = '0;
    end
    // The strap is sampled once, on the first edge after reset release.
    if (!st_ff.strap_done) begin
      nxt_st.strap = swap_strap_in;
      nxt_st.strap_done = 1'b1;
    end
    // Routing is decided in the cycle's own clock and shown one edge later,
    // which leaves the medium claim window intact.
    nxt_st.dvalid = cyc_valid_in;
    nxt_st.dtgt = TGT_PASS;
    nxt_st.dclaim = 1'b0;
    nxt_st.dpci = 1'b0;
    nxt_st.dfwd = 1'b0;
    nxt_st.dnmi = 1'b0;
    nxt_st.daddr = cyc_addr_in;
    if (cyc_valid_in) begin
      if (!cyc_mem_in) begin
        nxt_st.dtgt = (io_tgt != TGT_PASS) ? io_tgt : var_tgt;
        nxt_st.dclaim = nxt_st.dtgt != TGT_PASS;
        nxt_st.dpci = !cyc_from_pci_in && nxt_st.dtgt == TGT_PASS;
        nxt_st.dfwd = cyc_write_in && iomd_page_fwd(io_a);
        nxt_st.dnmi = cyc_write_in && iomd_nmi_upd(io_a);
      end else begin
        if (apic_hit) begin
          nxt_st.dtgt = TGT_IOAPIC;
        end else if (fwh_hit) begin
          nxt_st.dtgt = TGT_FWH;
        end else if (cyc_from_pci_in && !p2p_hit) begin
          nxt_st.dtgt = TGT_HUB;
        end else if (!cyc_from_pci_in && st_ff.ctrl[CTRL_SUBTR]) begin
          nxt_st.dtgt = TGT_LPC;
        end
        nxt_st.dclaim = nxt_st.dtgt != TGT_PASS;
        nxt_st.dpci = !cyc_from_pci_in;
        if (fwh_hit && bios_top && swap_eff) begin
          nxt_st.daddr[SWAP_BIT] = !cyc_addr_in[SWAP_BIT];
        end
      end
    end
  end

  // Only the battery-well reset reaches the swap bit.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign dec_valid_out = st_ff.dvalid;
  assign dec_target_out = st_ff.dtgt;
  assign dec_claim_out = st_ff.dclaim;
  assign dec_to_pci_out = st_ff.dpci;
  assign dec_also_fwd_out = st_ff.dfwd;
  assign dec_nmi_upd_out = st_ff.dnmi;
  assign dec_addr_out = st_ff.daddr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Every decision shows one edge after its cycle is taken, so each routing check
  // looks at the outputs with |=> against what was presented the edge before.
  a_unclaimed_to_pci: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && !cyc_from_pci_in && io_tgt == TGT_PASS
      && var_tgt == TGT_PASS |=> dec_to_pci_out && !dec_claim_out)
    else $error("Unclaimed host I/O not passed to PCI.");

  a_pci_fixed_claim: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && cyc_from_pci_in && io_tgt != TGT_PASS
      |=> dec_valid_out && dec_claim_out && !dec_to_pci_out)
    else $error("PCI master fixed I/O cycle not claimed.");

  a_dma_wronly: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && !cyc_write_in && io_a == 16'h009
      |=> dec_target_out != TGT_DMA)
    else $error("Write-only DMA port claimed on read.");

  a_nmi_update: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && cyc_write_in && io_a == 16'h070
      |=> dec_nmi_upd_out && dec_target_out == TGT_RTC)
    else $error("Write to 70h missed NMI update.");

  a_page_fwd: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && io_a == 16'h080
      |=> dec_target_out == TGT_DMA && dec_also_fwd_out == $past(cyc_write_in))
    else $error("Page register forwarding wrong.");

  a_f0_read: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && !cyc_write_in && io_a == 16'h0f0
      |=> dec_target_out == ($past(st_ff.ctrl[CTRL_F0EN]) ? TGT_PASS : TGT_LPC))
    else $error("F0h read routed wrongly.");

  a_host_mem_pci: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && cyc_mem_in && !cyc_from_pci_in |=> dec_to_pci_out)
    else $error("Host memory cycle not driven to PCI.");

  a_top_window: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && cyc_mem_in && cyc_addr_in[31:19] == 13'h1fff
      |=> dec_target_out == TGT_FWH && dec_claim_out)
    else $error("Top firmware window not decoded.");

  a_apic_claim: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && cyc_mem_in && apic_hit |=> dec_target_out == TGT_IOAPIC)
    else $error("I/O APIC window not claimed.");

  a_swap_a16: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && cyc_mem_in && bios_top
      |=> dec_addr_out[SWAP_BIT] == ($past(cyc_addr_in[SWAP_BIT]) ^ $past(swap_eff)))
    else $error("A16 swap wrong in BIOS space.");

  a_swap_busrst: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !host_bus_reset_n_in && !apb_wr |=> st_ff.swap_sw == $past(st_ff.swap_sw))
    else $error("Swap bit lost on bus reset.");

  // A strapped part must flip A16 whatever software last wrote to the swap bit.
  a_strap_force: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    st_ff.strap && cyc_valid_in && cyc_mem_in && bios_top
      |=> dec_addr_out[SWAP_BIT] != $past(cyc_addr_in[SWAP_BIT]))
    else $error("Forced swap was cleared.");

  a_reset_gen_claim: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && io_a == 16'hcf9
      |=> dec_target_out == TGT_RSTGEN && dec_claim_out)
    else $error("Reset generator port not claimed.");

  a_disk_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && io_a == 16'h170 && !st_ff.ctrl[CTRL_SEC]
      |=> dec_target_out != TGT_DISK)
    else $error("Disabled disk channel decoded.");

  a_lpc_var: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && !cyc_mem_in && io_tgt == TGT_PASS && var_tgt == TGT_LPC
      |=> dec_target_out == TGT_LPC && dec_claim_out)
    else $error("Generic LPC range not forwarded.");

  // Window zero of the top region must stay dark while its enable bit is clear.
  a_fwh_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cyc_valid_in && cyc_mem_in && cyc_addr_in[31:22] == FWH_TOP4M
      && cyc_addr_in[21:19] == 3'h0 && !st_ff.fwh_en[0]
      |=> dec_target_out != TGT_FWH)
    else $error("Disabled firmware window decoded.");

endmodule // iomd_decoder

/* File: tb/iomd_cycle_src.sv */
// Cycle source that stands in for the hub interface host bridge and PCI masters.
// Assumes the decoder takes one cycle at each rising edge while the strobe is high.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Cycle source
// ----------------------------------------------------------------------
module iomd_cycle_src
  import iomd_pkg::*;
(
  input wire logic clock_in,
  output logic cyc_valid_out,
  output logic cyc_mem_out,
  output logic cyc_write_out,
  output logic cyc_from_pci_out,
  output logic [31:0] cyc_addr_out
);
  // Idle bus from time zero.
  initial begin
    cyc_valid_out = 1'b0;
    cyc_mem_out = 1'b0;
    cyc_write_out = 1'b0;
    cyc_from_pci_out = 1'b0;
    cyc_addr_out = 32'h0000_0000;
  end

  // Launch one cycle just after the next edge; a following call keeps the strobe up,
  // so calls in a row give back-to-back cycles.
  task automatic put(input logic [2:0] k, input logic [31:0] a);
    @(posedge clock_in);
    cyc_valid_out <= 1'b1;
    {cyc_mem_out, cyc_write_out, cyc_from_pci_out} <= k;
    cyc_addr_out <= a;
  endtask

  // Drop the strobe and invert the address and write flag, so a stale address never passes for a new one.
  task automatic stop();
    @(posedge clock_in);
    cyc_valid_out <= 1'b0;
    cyc_addr_out <= ~cyc_addr_out;
    cyc_write_out <= ~cyc_write_out;
  endtask
endmodule // iomd_cycle_src

/* File: tb/iomd_decoder_tb.sv */
// Self-checking bench for the I/O and memory address decoder.
// Assumes a decision one edge after each cycle and APB answers with one wait state.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module iomd_decoder_tb
  import iomd_pkg::*;
();
  typedef struct {logic [2:0] k; logic [31:0] a; iomd_tgt_e t; logic [1:0] e;} iomd_row_s;
  // Cycle kinds as {memory, write, from PCI master}.
  localparam logic [2:0] IR = 3'b000;
  localparam logic [2:0] IW = 3'b010;
  localparam logic [2:0] PR = 3'b001;
  localparam logic [2:0] MR = 3'b100;
  localparam logic [2:0] MP = 3'b101;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic host_bus_reset_n_in = 1'b1;
  logic swap_strap_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cyc_valid;
  logic cyc_mem;
  logic cyc_write;
  logic cyc_pci;
  logic [31:0] cyc_addr;
  logic dec_valid_out;
  logic [3:0] dec_target_out;
  logic dec_claim_out;
  logic dec_to_pci_out;
  logic dec_also_fwd_out;
  logic dec_nmi_upd_out;
  logic [31:0] dec_addr_out;
  int fails = 0;
  int tests_run = 0;
  iomd_row_s rows[$];

  // A 100 ns clock.
  always #50 clock_in = ~clock_in;

  iomd_cycle_src i_src (.clock_in(clock_in), .cyc_valid_out(cyc_valid), .cyc_mem_out(cyc_mem),
    .cyc_write_out(cyc_write), .cyc_from_pci_out(cyc_pci), .cyc_addr_out(cyc_addr));

  iomd_decoder i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .host_bus_reset_n_in(host_bus_reset_n_in), .swap_strap_in(swap_strap_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc_valid_in(cyc_valid), .cyc_mem_in(cyc_mem),
    .cyc_write_in(cyc_write), .cyc_from_pci_in(cyc_pci), .cyc_addr_in(cyc_addr),
    .dec_valid_out(dec_valid_out), .dec_target_out(dec_target_out),
    .dec_claim_out(dec_claim_out), .dec_to_pci_out(dec_to_pci_out),
    .dec_also_fwd_out(dec_also_fwd_out), .dec_nmi_upd_out(dec_nmi_upd_out),
    .dec_addr_out(dec_addr_out));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk(e, xe);
  endtask

  task automatic add(input logic [2:0] k, input logic [31:0] a, input iomd_tgt_e t,
                     input logic [1:0] e = 2'b00);
    rows.push_back('{k, a, t, e});
  endtask

  // Host memory always goes to PCI first, host I/O only when nobody claims it.
  task automatic expect_dec(input iomd_row_s r, input logic [31:0] xa);
    chk(dec_valid_out, 32'h1);
    chk(dec_target_out, r.t);
    chk(dec_claim_out, r.t != TGT_PASS);
    chk(dec_also_fwd_out, r.e[1]);
    chk(dec_nmi_upd_out, r.e[0]);
    chk(dec_addr_out, xa);
    if (!r.k[0] && !r.e[1]) begin
      chk(dec_to_pci_out, r.k[2] || r.t == TGT_PASS);
    end
  endtask

  // Cycles go back to back; each answer is checked while the next cycle is taken.
  task automatic run_rows();
    foreach (rows[i]) begin
      i_src.put(rows[i].k, rows[i].a);
      if (i > 0) begin
        #1;
        expect_dec(rows[i-1], rows[i-1].a);
      end
    end
    i_src.stop();
    #1;
    expect_dec(rows[$], rows[$].a);
    @(posedge clock_in);
    #1;
    chk(dec_valid_out, 32'h0);
  endtask

  task automatic one(input logic [2:0] k, input logic [31:0] a, input iomd_tgt_e t,
                     input logic [31:0] xa);
    iomd_row_s r;
    r = '{k, a, t, 2'b00};
    i_src.put(k, a);
    i_src.stop();
    #1;
    expect_dec(r, xa);
  endtask

  task automatic pwr_reset(input logic strap);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    swap_strap_in <= strap;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_in);
    chk(dec_valid_out, 32'h0);
    rst_b_in <= 1'b1;
    rreg(OFS_CTRL, 32'h0, 1'b0);
    rreg(8'h40, 32'h0, 1'b1);
    wreg(OFS_CTRL, 32'h2);
    wreg(OFS_FWH_EN, 32'h1);
    wreg(OFS_PM_BASE, 32'h1000);
    wreg(OFS_GPIO_BASE, 32'h1100);
    wreg(OFS_LPC_GEN, 32'h1201);
    add(IR, 'h00, TGT_DMA);
    add(IR, 'h09, TGT_PASS);
    add(IW, 'h09, TGT_DMA);
    add(IR, 'hdd, TGT_PASS);
    add(IW, 'hdd, TGT_DMA);
    add(IR, 'h21, TGT_PIC);
    add(IW, 'h3d, TGT_PIC);
    add(IR, 'hb5, TGT_PIC);
    add(IR, 'h22, TGT_PASS);
    add(IR, 'h4d1, TGT_PIC);
    add(IR, 'h43, TGT_PASS);
    add(IW, 'h53, TGT_PIT);
    add(IR, 'h52, TGT_PIT);
    add(IR, 'h2f, TGT_LPC);
    add(IW, 'h66, TGT_LPC);
    add(IR, 'h63, TGT_NMI);
    add(IW, 'h67, TGT_NMI);
    add(IR, 'h70, TGT_PASS);
    add(IW, 'h70, TGT_RTC, 2'b01);
    add(IW, 'h76, TGT_RTC, 2'b01);
    add(IW, 'h77, TGT_RTC);
    add(IW, 'h80, TGT_DMA, 2'b10);
    add(IW, 'h8e, TGT_DMA, 2'b10);
    add(IR, 'h84, TGT_DMA);
    add(IR, 'h92, TGT_RSTGEN);
    add(IW, 'hcf9, TGT_RSTGEN);
    add(IR, 'hb3, TGT_PM);
    add(IW, 'hf0, TGT_FERR);
    add(IR, 'hf0, TGT_LPC);
    add(IR, 'h1f7, TGT_DISK);
    add(IW, 'h3f6, TGT_DISK);
    add(IR, 'h170, TGT_PASS);
    add(IR, 'h300, TGT_PASS);
    add(PR, 'h10, TGT_DMA);
    add(IR, 'h103f, TGT_PM);
    add(IR, 'h1040, TGT_PASS);
    add(IR, 'h1060, TGT_HEALTH);
    add(IR, 'h107f, TGT_HEALTH);
    add(IR, 'h1080, TGT_PASS);
    add(IW, 'h1100, TGT_GPIO);
    add(IR, 'h1140, TGT_PASS);
    add(IW, 'h127f, TGT_LPC);
    add(IR, 'h1280, TGT_PASS);
    add(MR, 'hfec0_0100, TGT_IOAPIC);
    add(MR, 'hfec0_0200, TGT_PASS);
    add(MR, 'hff87_ffff, TGT_FWH);
    add(MR, 'hffc8_0000, TGT_PASS);
    add(MR, 'h000e_0000, TGT_PASS);
    add(MR, 'hfff8_0000, TGT_FWH);
    add(MR, 'hffbf_ffff, TGT_FWH);
    add(MP, 'h4000_0000, TGT_HUB);
    add(MP, 'h0001_2340, TGT_PASS);
    run_rows();
    $display("Map table done");
    // Enable bits flipped, subtractive decode on, F0h reads left unclaimed.
    wreg(OFS_CTRL, 32'h9);
    wreg(OFS_FWH_EN, 32'h80);
    one(IR, 'hf0, TGT_PASS, 'hf0);
    one(IR, 'h1f0, TGT_PASS, 'h1f0);
    one(MR, 'h000f_fff0, TGT_FWH, 'h000f_fff0);
    one(MR, 'hffc0_0000, TGT_LPC, 'hffc0_0000);
    $display("Enable bits done");
    // Swap flips A16 of the top two blocks only.
    wreg(OFS_CTRL, 32'h11);
    one(MR, 'hfffe_1234, TGT_FWH, 'hffff_1234);
    one(MR, 'hffff_0000, TGT_FWH, 'hfffe_0000);
    one(MR, 'hfffd_0000, TGT_FWH, 'hfffd_0000);
    one(MR, 'hffbe_0000, TGT_FWH, 'hffbe_0000);
    @(posedge clock_in);
    host_bus_reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    host_bus_reset_n_in <= 1'b1;
    rreg(OFS_CTRL, 32'h10, 1'b0);
    one(MR, 'hfffe_0000, TGT_FWH, 'hffff_0000);
    pwr_reset(1'b0);
    rreg(OFS_CTRL, 32'h0, 1'b0);
    one(MR, 'hfffe_0000, TGT_FWH, 'hfffe_0000);
    $display("Swap and resets done");
    // A strapped swap cannot be cleared by software, only by a reboot without it.
    pwr_reset(1'b1);
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_CTRL, 32'h10, 1'b0);
    rreg(OFS_STATUS, 32'h10, 1'b0);
    one(MR, 'hfffe_0000, TGT_FWH, 'hffff_0000);
    pwr_reset(1'b0);
    one(MR, 'hfffe_0000, TGT_FWH, 'hfffe_0000);
    $display("Strap done");
    tally_and_finish();
  end
endmodule // iomd_decoder_tb
